// File: rtl/nsx_alu.sv
`default_nettype none
`include "nsx_alu_regs.svh"
// ****************************************
// Datapath for swap, mask tests, XOR and wait.
// ****************************************
module nsx_alu
  import nsx_alu_pkg::*;
(
  // Clock and resets.
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ext_reset_n_i,
  // Instruction issue.
  input  wire logic       op_valid_i,
  input  wire logic [7:0] opcode_i,
  input  wire logic [7:0] dst_addr_i,
  input  wire logic [7:0] src_i,
  output logic            op_ready_o,
  output logic            op_done_o,
  output logic            op_illegal_o,
  // Register file access.
  output logic            rf_re_o,
  output logic [7:0]      rf_raddr_o,
  input  wire logic [7:0] rf_rdata_i,
  output logic            rf_we_o,
  output logic [7:0]      rf_waddr_o,
  output logic [7:0]      rf_wdata_o,
  // Flags and interrupt wait.
  output logic [7:0]      flags_o,
  input  wire logic       int_req_i,
  input  wire logic       fast_int_req_i,
  input  wire logic       dma_req_i,
  output logic            waiting_o,
  output logic            int_svc_o,
  output logic            dma_grant_o,
  output logic            core_rst_o
);
  // CPU clock limit check at the start of simulation.
  localparam int unsigned MAXK = `NSX_CPU_MAX_KHZ;

  // State of the block.
  typedef struct packed {
    nsx_state_e st;     // Sequencer state.
    nsx_kind_e  kind;   // Current operation.
    logic [2:0] form;   // Operand form.
    logic [2:0] cnt;    // Cycles left.
    logic [7:0] daddr;  // Destination address.
    logic [7:0] dval;   // Destination value.
    logic [7:0] sval;   // Source value or indirect pointer.
    logic [7:0] flags;  // Flag byte.
    logic       done;   // Completion pulse.
    logic       ill;    // Unknown opcode pulse.
    logic       we;     // Write strobe.
    logic [7:0] wd;     // Write data.
    logic       svc;    // Interrupt service pulse.
    logic [1:0] irq_sync; // Two-stage interrupt synchroniser.
  } nsx_state_s;

  nsx_state_s s_q, s_d;
  logic       rst_core;         // Synchronised pin reset.
  logic       rst_all;          // Either reset.
  logic       irq_s;            // Synchronised interrupt.
  logic [7:0] res;              // Operation result.

  // Pin reset passes the synchroniser.
  nsx_alu_rstsync u_rst (
    .ref_clk_i     (ref_clk_i),
    .ext_reset_n_i (ext_reset_n_i),
    .core_rst_o    (rst_core)
  );
  assign rst_all    = rst_i | rst_core;
  assign core_rst_o = rst_core;

  // Decodes an opcode into its family only; the form is worked out by the caller.
  function automatic nsx_kind_e kind_of(input logic [7:0] op);
    logic [7:0] lo;
    lo = op & 8'h0F;
    kind_of = NSX_K_NONE;
    if (op == `NSX_OP_SWAP_R || op == `NSX_OP_SWAP_IR) begin
      kind_of = NSX_K_SWAP;
    end else if (op == `NSX_OP_WAIT) begin
      kind_of = NSX_K_WAIT;
    end else if (lo >= 8'h02 && lo <= 8'h06) begin
      if (op[7:4] == 4'h6) begin
        kind_of = NSX_K_CMASK;
      end else if (op[7:4] == 4'h7) begin
        kind_of = NSX_K_MASK;
      end else if (op[7:4] == 4'hB) begin
        kind_of = NSX_K_XOR;
      end
    end
  endfunction

  // Interrupt requests come from other logic but are synchronised for safety.
  // Only the second stage of the chain is read by the sequencer.
  assign irq_s = s_q.irq_sync[1];

  // Result of the current operation.
  always_comb begin
    case (s_q.kind)
      NSX_K_SWAP: res = {s_q.dval[3:0], s_q.dval[7:4]};
      NSX_K_CMASK: res = ~s_q.dval & s_q.sval;
      NSX_K_MASK:  res = s_q.dval & s_q.sval;
      NSX_K_XOR:  res = s_q.dval ^ s_q.sval;
      default:    res = 8'h00;
    endcase
  end

  // Next-state logic.
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.ill  = 1'b0;
    s_d.we   = 1'b0;
    s_d.svc  = 1'b0;
    // Interrupt request shifts through the two-stage chain every cycle.
    s_d.irq_sync = {s_q.irq_sync[0], int_req_i | fast_int_req_i};
    rf_re_o    = 1'b0;
    rf_raddr_o = 8'h00;
    if (s_q.cnt != 3'h0) begin
      s_d.cnt = s_q.cnt - 3'h1;
    end
    case (s_q.st)
      NSX_S_IDLE: begin
        if (op_valid_i) begin
          s_d.kind  = kind_of(opcode_i);
          s_d.form  = 3'(opcode_i[2:0] - 3'h2);
          s_d.daddr = dst_addr_i;
          s_d.sval  = src_i;
          if (s_d.kind == NSX_K_NONE) begin
            s_d.ill = 1'b1;
          end else if (s_d.kind == NSX_K_WAIT) begin
            s_d.st = NSX_S_WAIT;
          end else begin
            s_d.st = NSX_S_RDD;
            if (s_d.kind == NSX_K_SWAP) begin
              s_d.form = opcode_i[0] ? `NSX_FORM_RIR : `NSX_FORM_RR;
              s_d.cnt  = `NSX_CYC_SHORT - 3'h1;
            end else if (s_d.form == `NSX_FORM_RR) begin
              s_d.cnt = `NSX_CYC_SHORT - 3'h1;
            end else begin
              s_d.cnt = `NSX_CYC_LONG - 3'h1;
            end
          end
        end
      end
      NSX_S_RDD: begin
        // Swap indirect: read pointer first, then the addressed byte.
        rf_re_o    = 1'b1;
        rf_raddr_o = s_q.daddr;
        if (s_q.kind == NSX_K_SWAP && s_q.form == `NSX_FORM_RIR) begin
          s_d.daddr = rf_rdata_i;
          s_d.form  = `NSX_FORM_RR;
        end else begin
          s_d.dval = rf_rdata_i;
          s_d.st   = (s_q.kind == NSX_K_SWAP || s_q.form == `NSX_FORM_IM)
                     ? NSX_S_EXE : NSX_S_RDS;
        end
      end
      NSX_S_RDS: begin
        // Source register read, twice through the pointer for indirect forms.
        rf_re_o    = 1'b1;
        rf_raddr_o = s_q.sval;
        s_d.sval   = rf_rdata_i;
        if (s_q.form == `NSX_FORM_RIR || s_q.form == `NSX_FORM_GIR) begin
          s_d.form = `NSX_FORM_RR;
        end else begin
          s_d.st = NSX_S_EXE;
        end
      end
      NSX_S_EXE: begin
        s_d.flags[`NSX_FLG_Z] = (res == 8'h00);
        s_d.flags[`NSX_FLG_S] = res[7];
        if (s_q.kind != NSX_K_SWAP) begin
          s_d.flags[`NSX_FLG_V] = 1'b0;
        end
        // Only swap and XOR write back; tests leave operands alone.
        if (s_q.kind == NSX_K_SWAP || s_q.kind == NSX_K_XOR) begin
          s_d.we = 1'b1;
          s_d.wd = res;
        end
        s_d.st = NSX_S_HOLD;
      end
      NSX_S_HOLD: begin
        // Pads out the documented cycle count.
        // Done leaves on the edge that ends the last counted cycle.
        if (s_q.cnt == 3'h0) begin
          s_d.done = 1'b1;
          s_d.st   = NSX_S_IDLE;
          s_d.cnt  = 3'h0;
        end
      end
      NSX_S_WAIT: begin
        if (irq_s) begin
          s_d.svc  = 1'b1;
          s_d.done = 1'b1;
          s_d.st   = NSX_S_IDLE;
        end
      end
      default: s_d.st = NSX_S_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_i or posedge rst_all) begin
    if (rst_all) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs.
  assign op_ready_o   = (s_q.st == NSX_S_IDLE);
  assign op_done_o    = s_q.done;
  assign op_illegal_o = s_q.ill;
  assign rf_we_o      = s_q.we;
  assign rf_waddr_o   = s_q.daddr;
  assign rf_wdata_o   = s_q.wd;
  assign flags_o      = s_q.flags;
  assign waiting_o    = (s_q.st == NSX_S_WAIT);
  assign int_svc_o    = s_q.svc;
  assign dma_grant_o  = dma_req_i & (s_q.st == NSX_S_WAIT || s_q.st == NSX_S_IDLE);

  // ****************************************
  // Assertions.
  // ****************************************
  initial begin
    if (`NSX_REF_KHZ / 25 > MAXK) begin
      $error("CPU clock above limit");
    end
  end

  AST_SWAP_RESULT: assert property (@(posedge ref_clk_i) disable iff (rst_all)
    (s_q.st == NSX_S_EXE && s_q.kind == NSX_K_SWAP) |=> rf_we_o
      && rf_wdata_o == {$past(s_q.dval[3:0]), $past(s_q.dval[7:4])})
    else $error("swap result wrong");
  AST_ZERO_FLAG: assert property (@(posedge ref_clk_i) disable iff (rst_all)
    (s_q.st == NSX_S_EXE) |=> flags_o[`NSX_FLG_Z] == ($past(res) == 8'h00))
    else $error("zero flag wrong");
  AST_SIGN_FLAG: assert property (@(posedge ref_clk_i) disable iff (rst_all)
    (s_q.st == NSX_S_EXE) |=> flags_o[`NSX_FLG_S] == $past(res[7]))
    else $error("sign flag wrong");
  AST_TEST_NOWRITE: assert property (@(posedge ref_clk_i) disable iff (rst_all)
    (s_q.st == NSX_S_EXE && (s_q.kind == NSX_K_CMASK || s_q.kind == NSX_K_MASK)) |=> !rf_we_o)
    else $error("mask test wrote an operand");
  AST_SHORT_CYCLES: assert property (@(posedge ref_clk_i) disable iff (rst_all)
    (op_ready_o && op_valid_i && (opcode_i == 8'h62 || opcode_i == 8'hF0)) |-> ##5 op_done_o)
    else $error("short form cycle count wrong");
  AST_LONG_CYCLES: assert property (@(posedge ref_clk_i) disable iff (rst_all)
    (op_ready_o && op_valid_i && (opcode_i == 8'h74 || opcode_i == 8'h76)) |-> ##7 op_done_o)
    else $error("long form cycle count wrong");
  AST_V_CLEAR: assert property (@(posedge ref_clk_i) disable iff (rst_all)
    (s_q.st == NSX_S_EXE && s_q.kind != NSX_K_SWAP) |=> !flags_o[`NSX_FLG_V]
      && flags_o[`NSX_FLG_C] == $past(flags_o[`NSX_FLG_C]))
    else $error("overflow not cleared");
  AST_WAIT_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_all)
    (waiting_o && !irq_s) |=> waiting_o && !op_ready_o)
    else $error("wait left without interrupt");
  AST_WAIT_WAKE: assert property (@(posedge ref_clk_i) disable iff (rst_all)
    (waiting_o && irq_s) |=> int_svc_o && op_ready_o)
    else $error("wait not released");
  COV_SWAP: cover property (@(posedge ref_clk_i) s_q.kind == NSX_K_SWAP && op_done_o);
  COV_XOR: cover property (@(posedge ref_clk_i) s_q.kind == NSX_K_XOR && rf_we_o);
  COV_WAKE: cover property (@(posedge ref_clk_i) int_svc_o);
endmodule
`default_nettype wire

// File: rtl/nsx_alu_pkg.sv
`default_nettype none
// ****************************************
// Types shared by the datapath.
// ****************************************
package nsx_alu_pkg;
  // Operation class decoded from the opcode.
  typedef enum logic [2:0] {
    NSX_K_NONE = 3'h0,
    NSX_K_SWAP = 3'h1,
    NSX_K_CMASK = 3'h2,
    NSX_K_MASK  = 3'h3,
    NSX_K_XOR  = 3'h4,
    NSX_K_WAIT = 3'h5
  } nsx_kind_e;
  // Sequencer states, Gray coded from IDLE through HOLD along the usual path.
  typedef enum logic [2:0] {
    NSX_S_IDLE = 3'b000,
    NSX_S_RDD  = 3'b001,
    NSX_S_RDS  = 3'b011,
    NSX_S_EXE  = 3'b010,
    NSX_S_HOLD = 3'b110,
    NSX_S_WAIT = 3'b111
  } nsx_state_e;
endpackage
`default_nettype wire

// File: rtl/nsx_alu_regs.svh
// Summary of operation
// - Swap nibbles, opcodes F0/F1, four cycles.
// - Zero flag set when result is zero.
// - Sign flag takes result bit seven.
// - Complement test: flags only, operands kept.
// - Complement test opcodes 62-66, 4 or 6 cycles.
// - Plain test opcodes 72-76, flags only.
// - Tests and XOR clear overflow, keep others.
// - XOR writes result, opcodes B2-B6.
// - Wait halts fetch, DMA still proceeds.
// - Internal or fast interrupt ends wait.
// - Held in reset while ext_reset_n low.
// - CPU clock at most 8 MHz.
`ifndef NSX_ALU_REGS_SVH
`define NSX_ALU_REGS_SVH
// Opcodes of the handled instructions.
`define NSX_OP_SWAP_R   8'hF0
`define NSX_OP_SWAP_IR  8'hF1
`define NSX_OP_CMASK_BASE 8'h62
`define NSX_OP_MASK_BASE  8'h72
`define NSX_OP_XOR_BASE 8'hB2
`define NSX_OP_WAIT     8'h3F
// Operand form offsets from each family base.
`define NSX_FORM_RR     3'h0
`define NSX_FORM_RIR    3'h1
`define NSX_FORM_GR     3'h2
`define NSX_FORM_GIR    3'h3
`define NSX_FORM_IM     3'h4
// Cycle counts.
`define NSX_CYC_SHORT   3'h4
`define NSX_CYC_LONG    3'h6
// Flag bit positions in the flag byte.
`define NSX_FLG_C       7
`define NSX_FLG_Z       6
`define NSX_FLG_S       5
`define NSX_FLG_V       4
// Clock limit in kHz and the reference clock in kHz.
`define NSX_CPU_MAX_KHZ 8000
`define NSX_REF_KHZ     200000
`endif

// File: rtl/nsx_alu_rstsync.sv
`default_nettype none
// ****************************************
// Reset synchroniser for the active-low reset pin.
// ****************************************
module nsx_alu_rstsync (
  // Clock and pin.
  input  wire logic ref_clk_i,
  input  wire logic ext_reset_n_i,
  // Reset towards the core.
  output logic      core_rst_o
);
  logic [1:0] sync_q; // Two-stage shift chain.

  // Reset asserts at once and releases two edges after the pin goes high.
  always_ff @(posedge ref_clk_i or negedge ext_reset_n_i) begin
    if (!ext_reset_n_i) begin
      sync_q <= 2'h0;
    end else begin
      sync_q <= {sync_q[0], 1'b1};
    end
  end
  assign core_rst_o = ~sync_q[1];
endmodule
`default_nettype wire

// File: tb/nsx_alu_tb.sv
`default_nettype none
// ****************************************
// Self-checking bench for the datapath.
// ****************************************
module nsx_alu_tb
  import nsx_alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Design inputs, named as the ports they drive.
  logic       ref_clk_i, rst_i, ext_reset_n_i, op_valid_i;
  logic       int_req_i, fast_int_req_i, dma_req_i;
  logic [7:0] opcode_i, dst_addr_i, src_i, rf_rdata_i;
  // Design outputs.
  logic       op_ready_o, op_done_o, op_illegal_o, rf_re_o, rf_we_o;
  logic       waiting_o, int_svc_o, dma_grant_o, core_rst_o;
  logic [7:0] rf_raddr_o, rf_waddr_o, rf_wdata_o, flags_o;
  // Register file model and score counters.
  logic [7:0] rf [256];
  int         mismatches;
  int         samples_checked;

  nsx_alu DUT (.ref_clk_i, .rst_i, .ext_reset_n_i, .op_valid_i, .opcode_i,
    .dst_addr_i, .src_i, .op_ready_o, .op_done_o, .op_illegal_o, .rf_re_o,
    .rf_raddr_o, .rf_rdata_i, .rf_we_o, .rf_waddr_o, .rf_wdata_o, .flags_o,
    .int_req_i, .fast_int_req_i, .dma_req_i, .waiting_o, .int_svc_o,
    .dma_grant_o, .core_rst_o);

  // Clock of 5 ns; the register file answers reads at once.
  always #2.5 ref_clk_i = ~ref_clk_i;
  assign rf_rdata_i = rf[rf_raddr_o];
  // Writes land at the edge that sees the strobe.
  always @(posedge ref_clk_i) begin
    if (rf_we_o === 1'b1) begin
      rf[rf_waddr_o] <= rf_wdata_o;
    end
  end

  // Compares one value and reports a difference at once.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds a request until the edge that takes it, then drops it.
  task automatic take(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s);
    int n;
    n = 0;
    opcode_i = op;
    dst_addr_i = d;
    src_i = s;
    op_valid_i = 1'b1;
    while (op_ready_o !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i) #1;
      n++;
    end
    @(posedge ref_clk_i) #1;
    op_valid_i = 1'b0;
  endtask

  // Runs one operation and judges timing, write-back and flags.
  task automatic run_op(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s);
    logic [7:0] a, b, r, t, f0, wa, wd;
    int n, w, cyc, rd, nrd;
    take(op, d, s);
    // DMA asks all through the operation; it is granted only once idle.
    dma_req_i = 1'b1;
    // Expectations are formed after the take, when prior writes have landed.
    t = (op == 8'hF1) ? rf[d] : d;
    a = rf[t];
    case (op[2:0])
      3'h3, 3'h5: b = rf[rf[s]];
      3'h6: b = s;
      default: b = rf[s];
    endcase
    case (op[7:4])
      4'hF: r = {a[3:0], a[7:4]};
      4'h6: r = ~a & b;
      4'h7: r = a & b;
      default: r = a ^ b;
    endcase
    cyc = (op[7:4] == 4'hF || op[2:0] == 3'h2) ? 4 : 6;
    // One read per operand, one more through each pointer, none for an immediate.
    nrd = (op == 8'hF1 || op[2:0] == 3'h3 || op[2:0] == 3'h5) ? 2 : 1;
    nrd += (op[7:4] != 4'hF && op[2:0] != 3'h6) ? 1 : 0;
    f0 = flags_o;
    n = 0;
    w = 0;
    rd = 0;
    while (op_done_o !== 1'b1 && n < 20) begin
      rd += (rf_re_o === 1'b1);
      if (n == 1) begin
        chk(dma_grant_o, 8'h00);
      end
      if (rf_we_o === 1'b1) begin
        w++;
        wa = rf_waddr_o;
        wd = rf_wdata_o;
      end
      @(posedge ref_clk_i) #1;
      n++;
    end
    if (rf_we_o === 1'b1) begin
      w++;
      wa = rf_waddr_o;
      wd = rf_wdata_o;
    end
    chk(8'(n), 8'(cyc));
    chk(8'(rd), 8'(nrd));
    chk(dma_grant_o, 8'h01);
    dma_req_i = 1'b0;
    chk(8'(w), (op[7:4] == 4'h6 || op[7:4] == 4'h7) ? 8'h00 : 8'h01);
    if (w == 1) begin
      chk(wa, t);
      chk(wd, r);
    end
    chk(flags_o[6], r == 8'h00);
    chk(flags_o[5], r[7]);
    chk(flags_o[7], f0[7]);
    if (op[7:4] != 4'hF) begin
      chk(flags_o[4], 8'h00);
    end
  endtask

  // Nibble exchange, direct and through a pointer.
  task automatic t_swap();
    rf[0] = 8'h3E;
    rf[2] = 8'h03;
    rf[3] = 8'hA4;
    run_op(8'hF0, 8'h00, 8'h00);
    run_op(8'hF1, 8'h02, 8'h00);
  endtask

  // Every form of both mask tests and exclusive OR, back to back.
  task automatic t_families();
    logic [7:0] base [3];
    base = '{8'h62, 8'h72, 8'hB2};
    for (int k = 0; k < 3; k++) begin
      for (int f = 0; f < 5; f++) begin
        rf[0] = (f == 1) ? 8'hC7 : 8'h2B;
        rf[1] = 8'h02;
        rf[2] = 8'h23;
        run_op(base[k] + 8'(f), 8'h00, (f == 4) ? 8'h54 : 8'h01);
      end
    end
  endtask

  // Halt until an interrupt, with DMA granted meanwhile.
  task automatic t_wait(input bit fast);
    int n;
    take(8'h3F, 8'h00, 8'h00);
    repeat (3) @(posedge ref_clk_i) #1;
    chk(waiting_o, 8'h01);
    chk(op_ready_o, 8'h00);
    chk(op_done_o, 8'h00);
    dma_req_i = 1'b1;
    @(posedge ref_clk_i) #1;
    chk(dma_grant_o, 8'h01);
    chk(waiting_o, 8'h01);
    dma_req_i = 1'b0;
    if (fast) begin
      fast_int_req_i = 1'b1;
    end else begin
      int_req_i = 1'b1;
    end
    n = 0;
    while (op_done_o !== 1'b1 && n < 10) begin
      @(posedge ref_clk_i) #1;
      n++;
    end
    chk(int_svc_o, 8'h01);
    int_req_i = 1'b0;
    fast_int_req_i = 1'b0;
    @(posedge ref_clk_i) #1;
    chk(waiting_o, 8'h00);
  endtask

  // Opcode just past a family is not decoded.
  task automatic t_illegal();
    int il, dn;
    il = 0;
    dn = 0;
    take(8'h67, 8'h00, 8'h01);
    repeat (3) begin
      il += (op_illegal_o === 1'b1);
      dn += (op_done_o === 1'b1);
      @(posedge ref_clk_i) #1;
    end
    chk(8'(il), 8'h01);
    chk(8'(dn), 8'h00);
  endtask

  // Pin reset in mid-operation, then a clean operation.
  task automatic t_reset();
    take(8'hB4, 8'h00, 8'h01);
    @(posedge ref_clk_i) #1;
    ext_reset_n_i = 1'b0;
    repeat (3) @(posedge ref_clk_i) #1;
    chk(core_rst_o, 8'h01);
    chk(op_ready_o, 8'h01);
    ext_reset_n_i = 1'b1;
    repeat (3) @(posedge ref_clk_i) #1;
    chk(core_rst_o, 8'h00);
    run_op(8'hB6, 8'h00, 8'h54);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    {ref_clk_i, op_valid_i, int_req_i, fast_int_req_i, dma_req_i} = '0;
    {rst_i, ext_reset_n_i} = 2'b11;
    {opcode_i, dst_addr_i, src_i} = '0;
    foreach (rf[i]) rf[i] = 8'h00;
    repeat (12) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    @(posedge ref_clk_i) #1;
    t_swap();
    t_families();
    t_wait(1'b0);
    t_wait(1'b1);
    t_illegal();
    t_reset();
    test_done();
  end

  // Watchdog well beyond the expected run of under one microsecond.
  initial begin
    #20000;
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
